// [rtl/io_pad_configuration.sv]
// pad configuration block: per-pin pulls, open-drain, filters, wake and reset pins
`timescale 1ns/1ps
// What this block does
// - each pin except the two bus pins has its own pull-up and pull-down enable
// - pseudo open-drain mode drives only low, otherwise releases the pin
// - input glitch filter clocked by a selectable divided clock or the system clock, or bypassed
// - optional inversion of each input before it reaches the core
// - analog mode from the routing disconnects digital input and output
// - bus pins choose digital, standard/fast or fast-plus driver mode
// - bus pins have no pulls or pseudo mode; always open-drain
// - repeater mode enabled per pin except the two bus pins, independent of pull selection
// - wake pin fixed 20 ns filter; low wakes chip in deep power-down
// - wake pin function may be disabled only with wake timer oscillator on
// - reset pin fixed 20 ns filter; reset inert in deep power-down
// - crystal functions selected disable the digital part of their pins
// - pin configured as analog input has its digital part disabled
module io_pad_configuration (
  // clock and reset
  input  wire logic                         REF_CLK_I,
  input  wire logic                         RESET_I,
  // apb slave
  input  wire logic                         PSEL_I,
  input  wire logic                         PENABLE_I,
  input  wire logic                         PWRITE_I,
  input  wire logic [7:0]                   PADDR_I,
  input  wire logic [31:0]                  PWDATA_I,
  output logic      [31:0]                  PRDATA_O,
  output logic                              PREADY_O,
  output logic                              PSLVERR_O,
  // pads
  input  wire logic [pad_cfg_pkg::NUM_PINS-1:0] PAD_IN_I,
  output logic      [pad_cfg_pkg::NUM_PINS-1:0] PAD_OUT_O,
  output logic      [pad_cfg_pkg::NUM_PINS-1:0] PAD_OE_O,
  output logic      [pad_cfg_pkg::NUM_PINS-1:0] PULLUP_EN_O,
  output logic      [pad_cfg_pkg::NUM_PINS-1:0] PULLDN_EN_O,
  output logic      [pad_cfg_pkg::NUM_PINS-1:0] REPEATER_O,
  output logic      [3:0]                   BUS_MODE_O,
  // core side
  input  wire logic [pad_cfg_pkg::NUM_PINS-1:0] CORE_OUT_I,
  input  wire logic [pad_cfg_pkg::NUM_PINS-1:0] CORE_OE_I,
  output logic      [pad_cfg_pkg::NUM_PINS-1:0] CORE_IN_O,
  // routing and power state
  input  wire logic [pad_cfg_pkg::NUM_PINS-1:0] ANALOG_SEL_I,
  input  wire logic                         XTAL_IN_SEL_I,
  input  wire logic                         XTAL_OUT_SEL_I,
  input  wire logic                         RESET_FUNC_SEL_I,
  input  wire logic                         DEEP_PD_I,
  input  wire logic                         WKT_LPOSC_EN_I,
  // wake and reset requests
  output logic                              WAKE_REQ_O,
  output logic                              EXT_RESET_O
);

  localparam int NP = pad_cfg_pkg::NUM_PINS;
  localparam int ND = pad_cfg_pkg::NUM_DIVS;

  // =====================================================================
  // storage
  logic [pad_cfg_pkg::CFG_W-1:0] cfg_ff [0:NP-1];
  logic [pad_cfg_pkg::DIV_W-1:0] div_ff [0:ND-1];
  logic                          wdis_ff;
  logic [NP-1:0]                 sync1_ff;
  logic [NP-1:0]                 sync2_ff;
  logic [NP-1:0]                 filt_w;
  logic [NP-1:0]                 dig_off_w;
  logic [NP-1:0]                 open_w;
  logic [7:0]                    tick_w;
  logic                          wake_filt_w;
  logic                          rst_filt_w;

  // =====================================================================
  // apb decode
  wire        setup_w   = PSEL_I && !PENABLE_I;
  wire        access_w  = PSEL_I && PENABLE_I && PREADY_O;
  wire        aligned_w = (PADDR_I[1:0] == 2'b00);
  wire [4:0]  word_w    = PADDR_I[6:2];
  wire [2:0]  dword_w   = PADDR_I[4:2];
  wire        sel_cfg_w = aligned_w && !PADDR_I[7] && (word_w < 5'(NP));
  wire        sel_div_w = aligned_w && (PADDR_I[7:5] == pad_cfg_pkg::DIV_BASE_OFF[7:5])
                          && (dword_w < 3'(ND));
  wire        sel_ctl_w = (PADDR_I == pad_cfg_pkg::CTRL_OFF);
  wire        sel_sts_w = (PADDR_I == pad_cfg_pkg::STAT_OFF);
  wire        hit_w     = sel_cfg_w || sel_div_w || sel_ctl_w || sel_sts_w;
  wire        wr_w      = access_w && PWRITE_I && hit_w;
  wire [31:0] cfg_rd_w  = sel_cfg_w ? {19'h0, cfg_ff[word_w]} : 32'h0;
  wire [31:0] div_rd_w  = sel_div_w ? {24'h0, div_ff[dword_w]} : 32'h0;
  wire [31:0] ctl_rd_w  = sel_ctl_w ? {30'h0, WKT_LPOSC_EN_I, wdis_ff} : 32'h0;
  wire [31:0] sts_rd_w  = sel_sts_w ? {3'h0, CORE_IN_O} : 32'h0;
  wire [31:0] nxt_rdata = cfg_rd_w | div_rd_w | ctl_rd_w | sts_rd_w;

  // zero wait states: ready is raised for the access phase of each transfer
  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
    begin
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O  <= 32'h0;
    end
    else
    begin
      PREADY_O  <= setup_w;
      PSLVERR_O <= setup_w && !hit_w;
      PRDATA_O  <= (setup_w && !PWRITE_I) ? nxt_rdata : 32'h0;
    end
  end

  // =====================================================================
  // configuration registers
  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++)
    begin : g_cfg
      localparam logic IS_OD = (gi == pad_cfg_pkg::OD_PIN_A) || (gi == pad_cfg_pkg::OD_PIN_B);
      localparam logic [pad_cfg_pkg::CFG_W-1:0] RST_V =
        IS_OD ? pad_cfg_pkg::CFG_OD_RESET : pad_cfg_pkg::CFG_RESET;
      always_ff @(posedge REF_CLK_I)
      begin
        if (RESET_I)
          cfg_ff[gi] <= RST_V;
        else if (wr_w && sel_cfg_w && word_w == 5'(gi))
          cfg_ff[gi] <= PWDATA_I[pad_cfg_pkg::CFG_W-1:0];
      end
    end
    for (gi = 0; gi < ND; gi++)
    begin : g_div
      always_ff @(posedge REF_CLK_I)
      begin
        if (RESET_I)
          div_ff[gi] <= pad_cfg_pkg::DIV_RESET;
        else if (wr_w && sel_div_w && dword_w == 3'(gi))
          div_ff[gi] <= PWDATA_I[pad_cfg_pkg::DIV_W-1:0];
      end
      pad_clock_divider u_div (
        .clk_i  (REF_CLK_I),
        .rst_i  (RESET_I),
        .div_i  (div_ff[gi]),
        .tick_o (tick_w[gi])
      );
    end
  endgenerate

  // selector value seven runs the filter at the full system rate
  assign tick_w[7] = 1'b1;

  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
      wdis_ff <= 1'b0;
    else if (wr_w && sel_ctl_w)
      wdis_ff <= PWDATA_I[pad_cfg_pkg::CTRL_WDIS_BIT];
  end

  // =====================================================================
  // input synchronisers
  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
    begin
      sync1_ff <= '1;
      sync2_ff <= '1;
    end
    else
    begin
      sync1_ff <= PAD_IN_I;
      sync2_ff <= sync1_ff;
    end
  end

  // =====================================================================
  // per-pin pad logic
  generate
    for (gi = 0; gi < NP; gi++)
    begin : g_pin
      localparam logic IS_OD = (gi == pad_cfg_pkg::OD_PIN_A) || (gi == pad_cfg_pkg::OD_PIN_B);
      localparam logic IS_XI = (gi == pad_cfg_pkg::XIN_PIN_IDX);
      localparam logic IS_XO = (gi == pad_cfg_pkg::XOUT_PIN_IDX);
      wire [pad_cfg_pkg::CFG_W-1:0] c_w = cfg_ff[gi];
      wire [2:0] sel_w = c_w[pad_cfg_pkg::CFG_SEL_LSB +: pad_cfg_pkg::CFG_SEL_W];
      wire [1:0] cnt_w = c_w[pad_cfg_pkg::CFG_CNT_LSB +: pad_cfg_pkg::CFG_CNT_W];
      wire raw_w = sync2_ff[gi] ^ c_w[pad_cfg_pkg::CFG_INV_BIT];
      wire pulls_ok_w = !dig_off_w[gi] && !IS_OD;
      wire nxt_pu  = pulls_ok_w && c_w[pad_cfg_pkg::CFG_PU_BIT];
      wire nxt_pd  = pulls_ok_w && c_w[pad_cfg_pkg::CFG_PD_BIT];
      wire nxt_rep = pulls_ok_w && c_w[pad_cfg_pkg::CFG_REP_BIT];
      wire nxt_oe  = !dig_off_w[gi] && CORE_OE_I[gi] && (!open_w[gi] || !CORE_OUT_I[gi]);
      wire nxt_out = !dig_off_w[gi] && !open_w[gi] && CORE_OUT_I[gi];
      wire nxt_in  = !dig_off_w[gi] && filt_w[gi];

      // analog routing or crystal selection isolates the digital section
      assign dig_off_w[gi] = ANALOG_SEL_I[gi] || (IS_XI && XTAL_IN_SEL_I)
                             || (IS_XO && XTAL_OUT_SEL_I);
      // bus pins are open-drain for every routed function
      assign open_w[gi] = IS_OD || (!IS_OD && c_w[pad_cfg_pkg::CFG_POD_BIT]);

      pad_glitch_filter #(
        .RESET_LEVEL (1'b1)
      ) u_filt (
        .clk_i    (REF_CLK_I),
        .rst_i    (RESET_I),
        .tick_i   (tick_w[sel_w]),
        .bypass_i (c_w[pad_cfg_pkg::CFG_BYP_BIT]),
        .thresh_i (cnt_w),
        .din_i    (raw_w),
        .dout_o   (filt_w[gi])
      );

      always_ff @(posedge REF_CLK_I)
      begin
        if (RESET_I)
        begin
          PULLUP_EN_O[gi] <= !IS_OD;
          PULLDN_EN_O[gi] <= 1'b0;
          REPEATER_O[gi]  <= 1'b0;
          PAD_OE_O[gi]    <= 1'b0;
          PAD_OUT_O[gi]   <= 1'b0;
          CORE_IN_O[gi]   <= 1'b1;
        end
        else
        begin
          PULLUP_EN_O[gi] <= nxt_pu;
          PULLDN_EN_O[gi] <= nxt_pd;
          REPEATER_O[gi]  <= nxt_rep;
          PAD_OE_O[gi]    <= nxt_oe;
          PAD_OUT_O[gi]   <= nxt_out;
          CORE_IN_O[gi]   <= nxt_in;
        end
      end
    end
  endgenerate

  // =====================================================================
  // bus pin driver mode
  wire [1:0] mode_a_w = cfg_ff[pad_cfg_pkg::OD_PIN_A][pad_cfg_pkg::CFG_MODE_LSB +: 2];
  wire [1:0] mode_b_w = cfg_ff[pad_cfg_pkg::OD_PIN_B][pad_cfg_pkg::CFG_MODE_LSB +: 2];

  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
      BUS_MODE_O <= {pad_cfg_pkg::MODE_DIGITAL, pad_cfg_pkg::MODE_DIGITAL};
    else
      BUS_MODE_O <= {mode_b_w, mode_a_w};
  end

  // =====================================================================
  // fixed filters on wake and reset pins
  pad_glitch_filter #(
    .RESET_LEVEL (1'b1)
  ) u_wake_filt (
    .clk_i    (REF_CLK_I),
    .rst_i    (RESET_I),
    .tick_i   (1'b1),
    .bypass_i (1'b0),
    .thresh_i (2'(pad_cfg_pkg::FIXED_FILT_CYC - 1)),
    .din_i    (sync2_ff[pad_cfg_pkg::WAKE_PIN_IDX]),
    .dout_o   (wake_filt_w)
  );

  pad_glitch_filter #(
    .RESET_LEVEL (1'b1)
  ) u_rst_filt (
    .clk_i    (REF_CLK_I),
    .rst_i    (RESET_I),
    .tick_i   (1'b1),
    .bypass_i (1'b0),
    .thresh_i (2'(pad_cfg_pkg::FIXED_FILT_CYC - 1)),
    .din_i    (sync2_ff[pad_cfg_pkg::RESET_PIN_IDX]),
    .dout_o   (rst_filt_w)
  );

  // the disable request only counts while the wake timer oscillator runs
  wire wake_func_en_w = !(wdis_ff && WKT_LPOSC_EN_I);
  wire nxt_wake       = DEEP_PD_I && wake_func_en_w && !wake_filt_w;
  wire nxt_ext_rst    = RESET_FUNC_SEL_I && !DEEP_PD_I && !rst_filt_w;

  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
    begin
      WAKE_REQ_O  <= 1'b0;
      EXT_RESET_O <= 1'b0;
    end
    else
    begin
      WAKE_REQ_O  <= nxt_wake;
      EXT_RESET_O <= nxt_ext_rst;
    end
  end

  // =====================================================================
  // assertions
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RESET_I);

  sequence s_pin1_inv_bypass;
    (cfg_ff[1][pad_cfg_pkg::CFG_BYP_BIT] && cfg_ff[1][pad_cfg_pkg::CFG_INV_BIT]
     && !dig_off_w[1])[*3];
  endsequence

  a_od_no_pulls: assert property (
    !PULLUP_EN_O[pad_cfg_pkg::OD_PIN_A] && !PULLDN_EN_O[pad_cfg_pkg::OD_PIN_B]
    && !PULLUP_EN_O[pad_cfg_pkg::OD_PIN_B] && !PULLDN_EN_O[pad_cfg_pkg::OD_PIN_A])
    else $error("bus pin pull resistor enabled");

  a_open_low_only: assert property (
    ((PAD_OE_O & PAD_OUT_O & $past(open_w)) == '0))
    else $error("open-drain pin driven high");

  a_analog_isolate: assert property (
    ANALOG_SEL_I[0] |=> !PAD_OE_O[0] && !CORE_IN_O[0] && !PULLUP_EN_O[0])
    else $error("analog pin digital path active");

  a_analog_vector: assert property (
    ($past(dig_off_w) & (PAD_OE_O | CORE_IN_O | REPEATER_O | PULLDN_EN_O)) == '0)
    else $error("isolated pin digital section active");

  a_xtal_isolate: assert property (
    XTAL_IN_SEL_I |=> !PAD_OE_O[pad_cfg_pkg::XIN_PIN_IDX]
    && !CORE_IN_O[pad_cfg_pkg::XIN_PIN_IDX])
    else $error("crystal pin digital section active");

  a_pull_follow: assert property (
    (!dig_off_w[0] && cfg_ff[0][pad_cfg_pkg::CFG_PD_BIT]) |=> PULLDN_EN_O[0])
    else $error("pull-down not applied");

  a_repeat_follow: assert property (
    (!dig_off_w[1] && cfg_ff[1][pad_cfg_pkg::CFG_REP_BIT]) |=> REPEATER_O[1])
    else $error("repeater not applied");

  a_invert_path: assert property (
    s_pin1_inv_bypass |-> CORE_IN_O[1] == !$past(sync2_ff[1], 2))
    else $error("inverted bypass input wrong");

  a_bus_mode: assert property (
    BUS_MODE_O[1:0] == $past(mode_a_w))
    else $error("bus pin driver mode not applied");

  a_wake_only_dpd: assert property (
    WAKE_REQ_O |-> $past(DEEP_PD_I) && !$past(wake_filt_w))
    else $error("wake request outside deep power-down");

  a_wake_keep: assert property (
    (!WKT_LPOSC_EN_I && DEEP_PD_I && !wake_filt_w) |=> WAKE_REQ_O)
    else $error("wake pin disabled without wake oscillator");

  a_reset_dpd: assert property (
    DEEP_PD_I |=> !EXT_RESET_O)
    else $error("pin reset active in deep power-down");

endmodule : io_pad_configuration

// [rtl/pad_cfg_pkg.sv]
// constants shared by the pad configuration block and its leaf modules
package pad_cfg_pkg;

  // =====================================================================
  // pin population
  localparam int NUM_PINS      = 29;
  localparam int OD_PIN_A      = 10;
  localparam int OD_PIN_B      = 11;
  localparam int WAKE_PIN_IDX  = 4;
  localparam int RESET_PIN_IDX = 5;
  localparam int XIN_PIN_IDX   = 8;
  localparam int XOUT_PIN_IDX  = 9;
  localparam int NUM_DIVS      = 7;

  // =====================================================================
  // register byte offsets
  localparam logic [7:0] CFG_BASE_OFF = 8'h00;
  localparam logic [7:0] DIV_BASE_OFF = 8'h80;
  localparam logic [7:0] CTRL_OFF     = 8'ha0;
  localparam logic [7:0] STAT_OFF     = 8'ha4;

  // =====================================================================
  // pin config register fields
  localparam int CFG_PD_BIT   = 0;
  localparam int CFG_PU_BIT   = 1;
  localparam int CFG_REP_BIT  = 2;
  localparam int CFG_INV_BIT  = 3;
  localparam int CFG_POD_BIT  = 4;
  localparam int CFG_BYP_BIT  = 5;
  localparam int CFG_SEL_LSB  = 6;
  localparam int CFG_SEL_W    = 3;
  localparam int CFG_CNT_LSB  = 9;
  localparam int CFG_CNT_W    = 2;
  localparam int CFG_MODE_LSB = 11;
  localparam int CFG_MODE_W   = 2;
  localparam int CFG_W        = 13;
  localparam int DIV_W        = 8;
  localparam int CTRL_WDIS_BIT = 0;

  // reset values: pull-up on and filter bypassed; open-drain pins unpulled
  localparam logic [CFG_W-1:0] CFG_RESET    = 13'h0022;
  localparam logic [CFG_W-1:0] CFG_OD_RESET = 13'h0020;
  localparam logic [DIV_W-1:0] DIV_RESET    = 8'h00;

  // bus pin driver modes
  typedef enum logic [1:0] {
    MODE_DIGITAL = 2'b00,
    MODE_STD_FAST = 2'b01,
    MODE_FAST_PLUS = 2'b10
  } bus_mode_t;

  // =====================================================================
  // timing
  localparam int CLK_PERIOD_NS   = 20;
  localparam int FIXED_FILT_NS   = 20;
  localparam int FIXED_FILT_CYC  = (FIXED_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : pad_cfg_pkg

// [rtl/pad_clock_divider.sv]
// divider that produces one filter clock enable pulse every div_i cycles
`timescale 1ns/1ps
module pad_clock_divider (
  // clock and reset
  input  wire logic                           clk_i,
  input  wire logic                           rst_i,
  // control and enable out
  input  wire logic [pad_cfg_pkg::DIV_W-1:0]  div_i,
  output logic                                tick_o
);

  logic [pad_cfg_pkg::DIV_W-1:0] count_ff;
  wire  last_w = (count_ff >= div_i - 8'h01);

  always_ff @(posedge clk_i)
  begin
    if (rst_i || div_i == 8'h00)
    begin
      count_ff <= 8'h00;
      tick_o   <= 1'b0;
    end
    else
    begin
      count_ff <= last_w ? 8'h00 : count_ff + 8'h01;
      tick_o   <= last_w;
    end
  end

  a_tick_spacing: assert property (@(posedge clk_i) disable iff (rst_i)
    (tick_o && div_i > 8'h01 && $stable(div_i)) |=> !tick_o)
    else $error("filter clock enable pulses too close");

endmodule : pad_clock_divider

// [rtl/pad_glitch_filter.sv]
// glitch filter passing a level after it stays stable for thresh_i+1 enable ticks, or at once when bypassed
`timescale 1ns/1ps
module pad_glitch_filter #(
  parameter logic RESET_LEVEL = 1'b1
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // filter control
  input  wire logic       tick_i,
  input  wire logic       bypass_i,
  input  wire logic [1:0] thresh_i,
  // data
  input  wire logic       din_i,
  output logic            dout_o
);

  logic [1:0] cnt_ff;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_ff <= 2'h0;
      dout_o <= RESET_LEVEL;
    end
    else if (bypass_i)
    begin
      cnt_ff <= 2'h0;
      dout_o <= din_i;
    end
    else if (din_i == dout_o)
      cnt_ff <= 2'h0; // a glitch restarts the count
    else if (tick_i)
    begin
      if (cnt_ff == thresh_i)
      begin
        cnt_ff <= 2'h0;
        dout_o <= din_i; // stable for thresh_i+1 ticks
      end
      else
        cnt_ff <= cnt_ff + 2'h1;
    end
  end

  a_filter_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (!bypass_i && !tick_i) |=> $stable(dout_o))
    else $error("filter output moved without a filter clock tick");

endmodule : pad_glitch_filter

// [tb/io_pad_configuration_test.sv]
// self-checking bench of the pad configuration block
`timescale 1ns/1ps
module io_pad_configuration_test;
  localparam int N = pad_cfg_pkg::NUM_PINS;
  logic clk, rst, psel, penable, pwrite, xin, xout, rsel, dpd, lposc, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, rdv, lfsr;
  logic [N-1:0] cout, coe, asel, ev, een, lvl, po, poe, pu, pd, rep, cin;
  logic [31:0] prdata;
  logic pready, pslverr, wake, xrst;
  logic [3:0] bmode;
  int fails, check_count, p;

  // ======================================================================
  // design and pins
  io_pad_configuration u_dut (.REF_CLK_I(clk), .RESET_I(rst), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .PAD_IN_I(lvl),
    .PAD_OUT_O(po), .PAD_OE_O(poe), .PULLUP_EN_O(pu), .PULLDN_EN_O(pd),
    .REPEATER_O(rep), .BUS_MODE_O(bmode), .CORE_OUT_I(cout), .CORE_OE_I(coe),
    .CORE_IN_O(cin), .ANALOG_SEL_I(asel), .XTAL_IN_SEL_I(xin), .XTAL_OUT_SEL_I(xout),
    .RESET_FUNC_SEL_I(rsel), .DEEP_PD_I(dpd), .WKT_LPOSC_EN_I(lposc),
    .WAKE_REQ_O(wake), .EXT_RESET_O(xrst));
  pad_pin_model u_pins (.clk_i(clk), .pad_out_i(po), .pad_oe_i(poe), .pull_up_i(pu),
    .pull_dn_i(pd), .ext_val_i(ev), .ext_en_i(een), .level_o(lvl));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ======================================================================
  // helpers
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  function automatic logic [7:0] cfg_addr(input int pin);
    return pad_cfg_pkg::CFG_BASE_OFF + 8'(4 * pin);
  endfunction : cfg_addr

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so a following call never re-drives psel in this time step
    @(posedge clk);
  endtask : apb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic e);
    apb(1'b0, a, 32'h0);
    check(rdv, exp);
    check({31'h0, err}, {31'h0, e});
  endtask : rd_chk

  task automatic wait_sig(input int sel, input int idx, input logic val, input int n);
    logic cur;
    cur = 1'bx;
    repeat (n)
    begin
      @(posedge clk);
      cur = (sel == 0) ? cin[idx] : (sel == 1) ? wake : xrst;
      if (cur === val)
        break;
    end
    check({31'h0, cur}, {31'h0, val});
  endtask : wait_sig

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out

  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    close_out();
  end

  // ======================================================================
  // scenarios
  initial
  begin
    {rst, psel, penable, pwrite, xin, xout, rsel, dpd, lposc} = 9'h100;
    {paddr, pwdata, cout, coe, asel} = '0;
    ev = '1;
    een = 29'h33;
    lfsr = 32'd80044;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd_chk(cfg_addr(0), 32'h22, 1'b0);
    rd_chk(cfg_addr(10), 32'h20, 1'b0);
    check(32'(pu), 32'h1ffff3ff);
    rd_chk(8'h74, 32'h0, 1'b1);
    apb(1'b1, 8'h02, 32'h7);
    check({31'h0, err}, 32'h1);
    for (int k = 0; k < 12; k++)
    begin
      lfsr = lfsr_next(lfsr);
      p = int'(lfsr[15:8]) % N;
      if (p == 10 || p == 11)
        p = 2;
      apb(1'b1, cfg_addr(p), 32'h20 | (lfsr & 32'h7));
      cyc(3);
      check({29'h0, rep[p], pu[p], pd[p]}, lfsr & 32'h7);
    end
    apb(1'b1, cfg_addr(0), 32'h7c2);
    cyc(3);
    ev[0] <= 1'b0;
    cyc(3);
    ev[0] <= 1'b1;
    repeat (10)
    begin
      cyc(1);
      check({31'h0, cin[0]}, 32'h1);
    end
    ev[0] <= 1'b0;
    cyc(5);
    check({31'h0, cin[0]}, 32'h1);
    wait_sig(0, 0, 1'b0, 8);
    // divided filter clock one tick every 4 cycles; two ticks needed to pass
    apb(1'b1, pad_cfg_pkg::DIV_BASE_OFF + 8'h08, 32'h4);
    rd_chk(pad_cfg_pkg::DIV_BASE_OFF + 8'h08, 32'h4, 1'b0);
    apb(1'b1, cfg_addr(0), 32'h282);
    ev[0] <= 1'b1;
    cyc(8);
    check({31'h0, cin[0]}, 32'h0);
    wait_sig(0, 0, 1'b1, 6);
    apb(1'b1, cfg_addr(1), 32'h2a);
    wait_sig(0, 1, 1'b0, 6);
    ev[1] <= 1'b0;
    wait_sig(0, 1, 1'b1, 5);
    coe[2] <= 1'b1;
    cout[2] <= 1'b1;
    apb(1'b1, cfg_addr(2), 32'h22);
    cyc(3);
    check({30'h0, poe[2], po[2]}, 32'h3);
    apb(1'b1, cfg_addr(2), 32'h32);
    cyc(3);
    check({31'h0, poe[2]}, 32'h0);
    cout[2] <= 1'b0;
    cyc(3);
    check({30'h0, poe[2], lvl[2]}, 32'h2);
    coe[10] <= 1'b1;
    cout[10] <= 1'b1;
    apb(1'b1, cfg_addr(10), 32'h27);
    cyc(3);
    check({29'h0, pu[10], pd[10], poe[10]}, 32'h0);
    cout[10] <= 1'b0;
    cyc(3);
    check({31'h0, poe[10]}, 32'h1);
    for (int m = 0; m < 3; m++)
    begin
      apb(1'b1, cfg_addr(11), 32'h20 | (m << 11));
      cyc(3);
      check({30'h0, bmode[3:2]}, m);
    end
    {coe[3], coe[8], coe[9]} <= 3'b111;
    cyc(3);
    check({29'h0, poe[3], poe[8], poe[9]}, 32'h7);
    asel[3] <= 1'b1;
    {xin, xout} <= 2'b11;
    cyc(3);
    check({29'h0, poe[3], poe[8], poe[9]}, 32'h0);
    dpd <= 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      ev[4] <= 1'b0;
      wait_sig(1, 0, 1'b1, 6);
      ev[4] <= 1'b1;
      wait_sig(1, 0, 1'b0, 6);
      apb(1'b1, pad_cfg_pkg::CTRL_OFF, 32'h1);
    end
    lposc <= 1'b1;
    rd_chk(pad_cfg_pkg::CTRL_OFF, 32'h3, 1'b0);
    ev[4] <= 1'b0;
    cyc(8);
    check({31'h0, wake}, 32'h0);
    ev[4] <= 1'b1;
    dpd <= 1'b0;
    rsel <= 1'b1;
    ev[5] <= 1'b0;
    wait_sig(2, 0, 1'b1, 6);
    dpd <= 1'b1;
    wait_sig(2, 0, 1'b0, 4);
    cyc(2);
    close_out();
  end

endmodule : io_pad_configuration_test

// [tb/pad_pin_model.sv]
// external pin model: resolves each pad level from drivers, pulls and stimulus
`timescale 1ns/1ps
module pad_pin_model (
  // clock
  input  wire logic                             clk_i,
  // device side
  input  wire logic [pad_cfg_pkg::NUM_PINS-1:0] pad_out_i,
  input  wire logic [pad_cfg_pkg::NUM_PINS-1:0] pad_oe_i,
  input  wire logic [pad_cfg_pkg::NUM_PINS-1:0] pull_up_i,
  input  wire logic [pad_cfg_pkg::NUM_PINS-1:0] pull_dn_i,
  // external stimulus
  input  wire logic [pad_cfg_pkg::NUM_PINS-1:0] ext_val_i,
  input  wire logic [pad_cfg_pkg::NUM_PINS-1:0] ext_en_i,
  // resolved level
  output logic      [pad_cfg_pkg::NUM_PINS-1:0] level_o
);
  logic [pad_cfg_pkg::NUM_PINS-1:0] last_ff;

  // ======================================================================
  // resolution
  always_comb
  begin
    for (int i = 0; i < pad_cfg_pkg::NUM_PINS; i++)
    begin
      if (pad_oe_i[i])
        level_o[i] = pad_out_i[i];
      else if (ext_en_i[i])
        level_o[i] = ext_val_i[i];
      else if (i == pad_cfg_pkg::OD_PIN_A || i == pad_cfg_pkg::OD_PIN_B)
        level_o[i] = 1'b1;
      else if (pull_up_i[i])
        level_o[i] = 1'b1;
      else if (pull_dn_i[i])
        level_o[i] = 1'b0;
      else
        level_o[i] = ~last_ff[i]; // floating: no stable value
    end
  end

  always_ff @(posedge clk_i)
    last_ff <= level_o;

endmodule : pad_pin_model
